/* File: core/boot_strap_pkg.sv */
package boot_strap_pkg;

  // strap field layout
  localparam int STRAP_W     = 16;
  localparam int TOP_MSB     = 15;
  localparam int TOP_LSB     = 12;
  localparam int LOW_W       = 12;
  localparam int SEL_MSB     = 15;
  localparam int SEL_LSB     = 14;
  localparam int FUSE_CODE_W = 22;

  // buffer-gate select value that opens the low strap buffers
  localparam logic [1:0] LOW_OPEN_SEL = 2'h0;

  // reduced-mapping codes that hand the configuration to the fuse word
  localparam logic [3:0] FUSE_SEL_A = 4'hE;
  localparam logic [3:0] FUSE_SEL_B = 4'hF;

  // reset values
  localparam logic [15:0] CFG_RST  = 16'h0000;
  localparam logic [11:0] BUF_RST  = 12'h000;
  localparam logic [15:0] PIN_RST  = 16'h0000;

  // reset stretch after the last reset source lets go
  localparam int CLK_PERIOD_NS   = 8;
  localparam int RST_HOLD_NS     = 1000;
  localparam int RST_HOLD_CYCLES = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RST_LAST = 8'(RST_HOLD_CYCLES - 1);
  localparam logic [7:0] CNT_RST  = 8'h00;

  typedef enum logic [0:0] {
    ST_RESET = 1'b0,
    ST_RUN   = 1'b1
  } phase_t;

endpackage

/* File: core/fuse_secded_dec.sv */
`timescale 1ns/1ps
`default_nettype none

// 22-bit word: bits 20..0 hold hamming positions 1..21 (checks at powers of two),
// bit 21 is overall parity over the whole word
module fuse_secded_dec (
  input  wire logic [21:0] code,
  output logic      [15:0] data,
  output logic             corrected,
  output logic             uncorrectable
);

  logic [4:0]  syn;
  logic        par;
  logic [21:0] fixed;
  int          k;

  always_comb begin
    syn   = 5'h00;
    par   = ^code;
    fixed = code;
    data  = 16'h0000;
    k     = 0;
    for (int p = 1; p <= 21; p++) begin
      if (code[p-1]) begin
        syn = syn ^ 5'(p);
      end
    end
    // single error with a valid position gets flipped back
    if (par && (syn != 5'h00) && (syn <= 5'd21)) begin
      fixed[syn - 5'd1] = ~code[syn - 5'd1];
    end
    for (int p = 1; p <= 21; p++) begin
      if ((p & (p - 1)) != 0) begin
        data[k[3:0]] = fixed[p-1];
        k = k + 1;
      end
    end
    corrected     = par && (syn <= 5'd21);
    uncorrectable = (!par && (syn != 5'h00)) || (par && (syn > 5'd21));
  end

endmodule

`default_nettype wire

/* File: core/boot_strap_latch.sv */
`timescale 1ns/1ps
`default_nettype none

module boot_strap_latch (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        warm_reset_req_n,
  input  wire logic        map_full,
  input  wire logic [21:0] fuse_boot_value,
  input  wire logic [15:0] system_strap_pulls,
  input  wire logic [15:0] func_drive,
  input  wire logic [15:0] func_drive_en,
  output logic      [15:0] system_strap_pulls_drive,
  output logic      [15:0] system_strap_pulls_en,
  output logic      [11:0] strap_low_buf_en,
  output logic             reset_status_out,
  output logic      [15:0] boot_config,
  output logic             fuse_fixed,
  output logic             fuse_bad
);

  typedef struct packed {
    boot_strap_pkg::phase_t st;
    logic [7:0]             cnt;
    logic                   status;
    logic [15:0]            cfg;
    logic                   fixed;
    logic                   bad;
    logic [11:0]            buf_en;
    logic [15:0]            pin_o;
    logic [15:0]            pin_oe;
  } state_t;

  state_t cur_ff;
  state_t nxt_st;

  logic [15:0] fuse_data;
  logic        fuse_corr;
  logic        fuse_dbl;
  logic        use_fuse;
  logic [15:0] cfg_sel;
  logic [3:0]  top_sel;

  fuse_secded_dec fuse_secded_dec_i (
    .code          (fuse_boot_value),
    .data          (fuse_data),
    .corrected     (fuse_corr),
    .uncorrectable (fuse_dbl)
  );

  always_comb begin
    top_sel  = system_strap_pulls[boot_strap_pkg::TOP_MSB:boot_strap_pkg::TOP_LSB];
    use_fuse = !map_full &&
               ((top_sel == boot_strap_pkg::FUSE_SEL_A) ||
                (top_sel == boot_strap_pkg::FUSE_SEL_B));
    if (use_fuse) begin
      cfg_sel = fuse_data;
    end else if (map_full) begin
      // a closed low buffer reads zero, as the pad would not pass the level
      cfg_sel = {top_sel, system_strap_pulls[11:0] & cur_ff.buf_en};
    end else begin
      cfg_sel = {top_sel, 12'h000};
    end
  end

  always_comb begin
    nxt_st = cur_ff;
    unique case (cur_ff.st)
      boot_strap_pkg::ST_RESET: begin
        if (!warm_reset_req_n) begin
          nxt_st.cnt = boot_strap_pkg::CNT_RST;
        end else if (cur_ff.cnt == boot_strap_pkg::RST_LAST) begin
          nxt_st.st = boot_strap_pkg::ST_RUN;
        end else begin
          nxt_st.cnt = cur_ff.cnt + 8'h01;
        end
      end
      boot_strap_pkg::ST_RUN: begin
        if (!warm_reset_req_n) begin
          nxt_st.st  = boot_strap_pkg::ST_RESET;
          nxt_st.cnt = boot_strap_pkg::CNT_RST;
        end
      end
    endcase
    nxt_st.status = (nxt_st.st == boot_strap_pkg::ST_RUN);
    // only the reset-to-run step loads; apart from the rstn clear to CFG_RST nothing writes cfg
    if (cur_ff.st == boot_strap_pkg::ST_RESET && nxt_st.st == boot_strap_pkg::ST_RUN) begin
      nxt_st.cfg   = cfg_sel;
      nxt_st.fixed = use_fuse && fuse_corr;
      nxt_st.bad   = use_fuse && fuse_dbl;
    end
    if (nxt_st.st == boot_strap_pkg::ST_RUN) begin
      nxt_st.buf_en = 12'hFFF;
      nxt_st.pin_o  = func_drive;
      nxt_st.pin_oe = func_drive_en;
    end else begin
      // avoids current in floating low pads: closed whenever strap bits 15:14 differ from LOW_OPEN_SEL, whatever map_full is
      nxt_st.buf_en = {boot_strap_pkg::LOW_W{system_strap_pulls[boot_strap_pkg::SEL_MSB:
                      boot_strap_pkg::SEL_LSB] == boot_strap_pkg::LOW_OPEN_SEL}};
      nxt_st.pin_o  = boot_strap_pkg::PIN_RST;
      nxt_st.pin_oe = boot_strap_pkg::PIN_RST;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cur_ff.st     <= boot_strap_pkg::ST_RESET;
      cur_ff.cnt    <= boot_strap_pkg::CNT_RST;
      cur_ff.status <= 1'b0;
      cur_ff.cfg    <= boot_strap_pkg::CFG_RST;
      cur_ff.fixed  <= 1'b0;
      cur_ff.bad    <= 1'b0;
      cur_ff.buf_en <= boot_strap_pkg::BUF_RST;
      cur_ff.pin_o  <= boot_strap_pkg::PIN_RST;
      cur_ff.pin_oe <= boot_strap_pkg::PIN_RST;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign reset_status_out         = cur_ff.status;
  assign boot_config              = cur_ff.cfg;
  assign fuse_fixed               = cur_ff.fixed;
  assign fuse_bad                 = cur_ff.bad;
  assign strap_low_buf_en         = cur_ff.buf_en;
  assign system_strap_pulls_drive = cur_ff.pin_o;
  assign system_strap_pulls_en    = cur_ff.pin_oe;

  // helper: true once a full cycle has passed since reset release
  logic past_ok_ff;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      past_ok_ff <= 1'b0;
    end else begin
      past_ok_ff <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  status_in_reset_a: assert property (
    (cur_ff.st == boot_strap_pkg::ST_RESET) |-> !reset_status_out)
    else $error("status high while reset in progress");

  warm_drop_a: assert property (
    reset_status_out && !warm_reset_req_n |=> !reset_status_out [*2])
    else $error("status did not drop on warm reset");

  capture_rise_a: assert property (
    $rose(reset_status_out) |-> boot_config == $past(cfg_sel))
    else $error("configuration not captured at status rise");

  config_hold_a: assert property (
    reset_status_out && $past(reset_status_out) |-> $stable(boot_config))
    else $error("configuration changed after capture");

  low_gate_a: assert property (
    past_ok_ff && !reset_status_out |->
      strap_low_buf_en == {12{$past(system_strap_pulls[15:14]) == 2'h0}})
    else $error("low strap buffers gated wrongly in reset");

  reduced_map_a: assert property (
    $rose(reset_status_out) && !$past(map_full) && !$past(use_fuse) |->
      boot_config == {$past(system_strap_pulls[15:12]), 12'h000})
    else $error("reduced mapping captured wrong bits");

  fuse_take_a: assert property (
    $rose(reset_status_out) && $past(use_fuse) |-> boot_config == $past(fuse_data))
    else $error("fuse value not taken for fuse code");

  fuse_flag_a: assert property (
    $rose(reset_status_out) |-> fuse_bad == $past(use_fuse && fuse_dbl))
    else $error("double error flag wrong");

  func_pin_a: assert property (
    past_ok_ff && reset_status_out |-> system_strap_pulls_en == $past(func_drive_en))
    else $error("pin enable not following functional request");

  pins_quiet_a: assert property (
    !reset_status_out |-> system_strap_pulls_en == 16'h0000)
    else $error("strap pins driven during reset");

endmodule

`default_nettype wire

/* File: verif/strap_board.sv */
`timescale 1ns/1ps
`default_nettype none

module strap_board (
  input  wire logic        reset_status_out,
  input  wire logic [15:0] strap_val,
  input  wire logic [15:0] dev_drive,
  input  wire logic [15:0] dev_en,
  output logic      [15:0] pad
);
  // released lines show the inverse once reset_status_out is high, so a stale strap level cannot pass by luck
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (dev_en[i]) pad[i] = dev_drive[i];
      else if (!reset_status_out) pad[i] = strap_val[i];
      else pad[i] = ~strap_val[i];
    end
  end
endmodule

`default_nettype wire

/* File: verif/boot_strap_latch_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module boot_strap_latch_tb;
  logic        core_clk = 1'b0;
  logic        rstn     = 1'b0;
  logic        warm_n   = 1'b1;
  logic        map_full = 1'b0;
  logic [21:0] fuse     = 22'h00_0000;
  logic [15:0] strap    = 16'h0000;
  logic [15:0] fdrv     = 16'h0000;
  logic [15:0] fen      = 16'h0000;
  logic [15:0] pad, pdrv, pen, cfg;
  logic [11:0] lbe;
  logic        st, ffix, fbad;
  int          mismatches = 0;
  int          checked    = 0;
  int          cyc        = 0;

  always #4 core_clk = ~core_clk;

  strap_board strap_board_i (.reset_status_out(st), .strap_val(strap), .dev_drive(pdrv),
    .dev_en(pen), .pad(pad));

  boot_strap_latch boot_strap_latch_i (.core_clk(core_clk), .rstn(rstn),
    .warm_reset_req_n(warm_n), .map_full(map_full), .fuse_boot_value(fuse),
    .system_strap_pulls(pad), .func_drive(fdrv), .func_drive_en(fen),
    .system_strap_pulls_drive(pdrv), .system_strap_pulls_en(pen), .strap_low_buf_en(lbe),
    .reset_status_out(st), .boot_config(cfg), .fuse_fixed(ffix), .fuse_bad(fbad));

  task automatic report_and_stop();
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // data fills the non-power-of-two positions; checks cover their own bit of the index
  function automatic logic [21:0] enc(input logic [15:0] d);
    logic [21:0] c;
    int          k;
    c = 22'h00_0000;
    k = 0;
    for (int p = 1; p <= 21; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p-1] = d[k];
        k++;
      end
    end
    for (int b = 1; b <= 16; b = b * 2) begin
      for (int p = 1; p <= 21; p++) begin
        if ((p & b) != 0 && p != b) c[b-1] = c[b-1] ^ c[p-1];
      end
    end
    c[21] = ^c[20:0];
    return c;
  endfunction

  task automatic wait_status(output int n);
    n = 0;
    while (st !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      #1;
      n++;
      if (n == 3) chk(lbe, (strap[15:14] == 2'h0) ? 12'hfff : 12'h000);
    end
  endtask

  task automatic boot(input logic [15:0] s, input logic full, input logic [21:0] f);
    int n;
    rstn = 1'b0;
    strap = s;
    map_full = full;
    fuse = f;
    repeat (5) @(posedge core_clk);
    #1 chk(st, 1'b0);
    rstn = 1'b1;
    wait_status(n);
    chk(n, boot_strap_pkg::RST_HOLD_CYCLES);
  endtask

  task automatic s_full_map();
    boot(16'h0abc, 1'b1, 22'h00_0000);
    chk(cfg, 16'h0abc);
    boot(16'h4abc, 1'b1, 22'h00_0000);
    chk(cfg, 16'h4000);
  endtask

  task automatic s_reduced_map();
    boot(16'h7abc, 1'b0, 22'h00_0000);
    chk(cfg, 16'h7000);
  endtask

  task automatic s_fuse();
    boot(16'he123, 1'b0, enc(16'hbeef));
    chk({fbad, ffix, cfg}, {2'b00, 16'hbeef});
    boot(16'hf000, 1'b0, enc(16'h1234) ^ 22'h00_0400);
    chk({fbad, ffix, cfg}, {2'b01, 16'h1234});
    boot(16'hf000, 1'b0, enc(16'h1234) ^ 22'h00_0003);
    chk(fbad, 1'b1);
    // a fuse code in the full mapping is an ordinary strap value
    boot(16'he123, 1'b1, enc(16'hbeef));
    chk({fbad, ffix, cfg}, {2'b00, 16'he000});
  endtask

  task automatic s_hold_and_pins();
    boot(16'h2555, 1'b1, 22'h00_0000);
    strap = 16'h0000;
    fdrv = 16'ha5a5;
    fen = 16'hff00;
    repeat (3) @(posedge core_clk);
    #1 chk(cfg, 16'h2555);
    chk({pen, pdrv}, {16'hff00, 16'ha5a5});
    fen = 16'h0000;
  endtask

  task automatic s_warm();
    int n;
    strap = 16'h3000;
    warm_n = 1'b0;
    @(posedge core_clk);
    #1 chk(st, 1'b0);
    chk(cfg, 16'h2555);
    warm_n = 1'b1;
    wait_status(n);
    chk(n, boot_strap_pkg::RST_HOLD_CYCLES);
    chk(cfg, 16'h3000);
  endtask

  // eight boots and one warm reset of some 130 cycles each
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end

  initial begin
    s_full_map();
    s_reduced_map();
    s_fuse();
    s_hold_and_pins();
    s_warm();
    report_and_stop();
  end
endmodule

`default_nettype wire
